// ==== design/ldpc_dimming.v ====
// Functional notes
// - enable high: switching on and series output switch on.
// - enable low: switching stopped and series output switch off.
// - gate drive is a buffered copy of the enable/dimming level.
// - average current follows external high-time fraction times full current.
// - series switch opens the string during every low dimming phase.
// - select high: generator off, full 100 percent output.
// - select low: generator on, gating switching and series switch.
// - duty percent equals duty kilohms times 0.1 divided by 3.6.
// - generator frequency programmable from 100 Hz to 2 kHz.
// - frequency hertz equals 2e4 divided by frequency kilohms.
// - fault logic also forces the gate drive off.
`timescale 1ns/100ps
`default_nettype none
`include "ldpc_regs.vh"

module ldpc_dimming #(
    parameter integer CLK_HZ  = `LDPC_CLK_HZ,
    parameter integer TICK_HZ = `LDPC_TICK_HZ
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        en_dim_pin,
    input  wire        internal_dim_select,
    input  wire        fault_in,
    output wire        switching_enable,
    output wire        output_switch_gate_drive,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready
);

    localparam integer TICK_DIV = CLK_HZ / TICK_HZ;
    localparam [1:0]   RESP_OK  = 2'b00;
    localparam [1:0]   RESP_ERR = 2'b10;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    localparam integer NUM_PINS = 3;

    wire [NUM_PINS-1:0] pin_raw = {fault_in, internal_dim_select, en_dim_pin};
    wire [NUM_PINS-1:0] pin_lvl;

    // only the second flop of each pair is read, so a metastable first
    // stage never reaches the gating logic
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_sync
            reg [1:0] sync_q;

            always @(posedge aclk) begin
                if (!aresetn)
                    sync_q <= 2'b00;
                else
                    sync_q <= {sync_q[0], pin_raw[gi]};
            end

            assign pin_lvl[gi] = sync_q[1];
        end
    endgenerate

    wire en_lvl  = pin_lvl[0];
    wire sel_lvl = pin_lvl[1];
    wire flt_lvl = pin_lvl[2];

    // ****************************************************************
    // registers
    // ****************************************************************
    reg [15:0] duty_q;
    reg [15:0] freq_q;
    reg        sw_fault_q;
    reg        gen_q;
    reg        gate_q;
    reg        sw_en_q;

    // ****************************************************************
    // tick divider: one-cycle enable at TICK_HZ
    // ****************************************************************
    reg [15:0] div_q;
    wire       tick = (div_q == 16'h0000);

    always @(posedge aclk) begin
        if (!aresetn)
            div_q <= 16'h0000;
        else if (tick)
            div_q <= TICK_DIV[15:0] - 16'h0001;
        else
            div_q <= div_q - 16'h0001;
    end

    // ****************************************************************
    // internal dimming generator
    // ****************************************************************
    // period in ticks = TICK_HZ * kohm / 2e4; high ticks = period *
    // (kohm_duty * 0.1 / 3.6) / 100. computed in 48 bits; the
    // divide is static per setting, so synthesis cost is accepted.
    function [31:0] period_ticks;
        input [15:0] kohm;
        reg   [47:0] p;
        begin
            p = (TICK_HZ * {32'h0, kohm}) / `LDPC_FREQ_NUM;
            period_ticks = (p == 48'h0) ? 32'h1 : p[31:0];
        end
    endfunction

    // 48-bit product: a long period times a large duty setting would
    // wrap a 32-bit intermediate and give a tiny high time
    function [31:0] high_ticks;
        input [31:0] per;
        input [15:0] kohm;
        reg   [47:0] h;
        begin
            h = ({16'h0, per} * `LDPC_DUTY_MUL_TENTH * {32'h0, kohm})
                / (`LDPC_DUTY_DIV_TENTH * 100);
            high_ticks = (h > {16'h0, per}) ? per : h[31:0];
        end
    endfunction

    wire [31:0] per_w  = period_ticks(freq_q);
    wire [31:0] high_w = high_ticks(per_w, duty_q);
    reg  [31:0] phase_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= 32'h0;
            gen_q   <= 1'b0;
        end else if (sel_lvl) begin
            phase_q <= 32'h0;
            gen_q   <= 1'b1;
        end else if (tick) begin
            if (phase_q + 32'h1 >= per_w)
                phase_q <= 32'h0;
            else
                phase_q <= phase_q + 32'h1;
            gen_q <= (phase_q < high_w);
        end
    end

    // ****************************************************************
    // gating of switching and series switch
    // ****************************************************************
    // the gate follows the enable level directly, so external duty
    // maps one to one onto average current; no filtering applied.
    wire fault_any = flt_lvl | sw_fault_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            gate_q  <= 1'b0;
            sw_en_q <= 1'b0;
        end else begin
            sw_en_q <= en_lvl & gen_q;
            gate_q  <= en_lvl & gen_q & ~fault_any;
        end
    end

    assign switching_enable         = sw_en_q;
    assign output_switch_gate_drive = gate_q;

    // ****************************************************************
    // axi4-lite slave
    // ****************************************************************
    reg        aw_hold_q;
    reg [7:0]  awaddr_q;
    reg        w_hold_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    reg        rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0]  rresp_q;

    assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    wire aw_have = aw_hold_q | s_axi_awvalid;
    wire w_have  = w_hold_q | s_axi_wvalid;
    wire [7:0]  wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
    wire [3:0]  ws = w_hold_q ? wstrb_q : s_axi_wstrb;
    wire do_wr = aw_have & w_have & ~bvalid_q;

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  stb;
        begin
            merge16[7:0]  = stb[0] ? dat[7:0]  : old[7:0];
            merge16[15:8] = stb[1] ? dat[15:8] : old[15:8];
        end
    endfunction

    // one map check for both channels keeps the error responses aligned
    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a == `LDPC_ADDR_CTRL) || (a == `LDPC_ADDR_DUTY) ||
                       (a == `LDPC_ADDR_FREQ) || (a == `LDPC_ADDR_STATUS);
        end
    endfunction

    // status bit positions come from the shared header so software and
    // hardware cannot drift apart
    function [31:0] status_word;
        input en;
        input sel;
        input gen;
        input gate;
        input flt;
        begin
            status_word                     = 32'h0;
            status_word[`LDPC_ST_EN_BIT]    = en;
            status_word[`LDPC_ST_SEL_BIT]   = sel;
            status_word[`LDPC_ST_GEN_BIT]   = gen;
            status_word[`LDPC_ST_GATE_BIT]  = gate;
            status_word[`LDPC_ST_FAULT_BIT] = flt;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q  <= 1'b0;
            awaddr_q   <= 8'h00;
            w_hold_q   <= 1'b0;
            wdata_q    <= 32'h0;
            wstrb_q    <= 4'h0;
            bvalid_q   <= 1'b0;
            bresp_q    <= RESP_OK;
            duty_q     <= `LDPC_DUTY_RST;
            freq_q     <= `LDPC_FREQ_RST;
            sw_fault_q <= 1'b0;
        end else begin
            if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= addr_hit(wa) ? RESP_OK : RESP_ERR;
                case (wa)
                `LDPC_ADDR_CTRL:
                    if (ws[0])
                        sw_fault_q <= wd[`LDPC_CTRL_FAULT_BIT];
                `LDPC_ADDR_DUTY: duty_q <= merge16(duty_q, wd, ws);
                `LDPC_ADDR_FREQ: freq_q <= merge16(freq_q, wd, ws);
                default: ;
                endcase
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_hold_q <= 1'b1;
                    wdata_q  <= s_axi_wdata;
                    wstrb_q  <= s_axi_wstrb;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OK;
        end else if (rvalid_q) begin
            if (s_axi_rready)
                rvalid_q <= 1'b0;
        end else if (s_axi_arvalid) begin
            rvalid_q <= 1'b1;
            rresp_q  <= addr_hit(s_axi_araddr) ? RESP_OK : RESP_ERR;
            rdata_q  <= 32'h0;
            case (s_axi_araddr)
            `LDPC_ADDR_CTRL:   rdata_q <= {31'h0, sw_fault_q};
            `LDPC_ADDR_DUTY:   rdata_q <= {16'h0, duty_q};
            `LDPC_ADDR_FREQ:   rdata_q <= {16'h0, freq_q};
            `LDPC_ADDR_STATUS: rdata_q <= status_word(en_lvl, sel_lvl, gen_q,
                                                      gate_q, fault_any);
            default:           rdata_q <= 32'h0;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== design/ldpc_regs.vh ====
`ifndef LDPC_REGS_VH
`define LDPC_REGS_VH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define LDPC_ADDR_CTRL      8'h00
`define LDPC_ADDR_DUTY      8'h04
`define LDPC_ADDR_FREQ      8'h08
`define LDPC_ADDR_STATUS    8'h0c

// ****************************************************************
// fields and reset values
// ****************************************************************
`define LDPC_CTRL_FAULT_BIT 0
`define LDPC_ST_EN_BIT      0
`define LDPC_ST_SEL_BIT     1
`define LDPC_ST_GEN_BIT     2
`define LDPC_ST_GATE_BIT    3
`define LDPC_ST_FAULT_BIT   4
`define LDPC_DUTY_RST       16'd1800
`define LDPC_FREQ_RST       16'd100

// ****************************************************************
// timing: clock and duty/frequency scaling
// ****************************************************************
`define LDPC_CLK_HZ         125000000
`define LDPC_FREQ_NUM       20000
`define LDPC_DUTY_MUL_TENTH 1
`define LDPC_DUTY_DIV_TENTH 36
`define LDPC_DUTY_FULL      1000
`define LDPC_TICK_HZ        100000

`endif

// ==== tb/ldpc_dim_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// lamp-side source driving the combined enable pin
// ****************************************************************
module ldpc_dim_src (
    input  wire logic        aclk,
    input  wire logic        run,
    input  wire logic [15:0] hi_cyc,
    input  wire logic [15:0] lo_cyc,
    output var  logic        en_dim_pin
);
    logic [15:0] cnt_q = 16'h0;
    // stopped source reads low, as the pin's pulldown would
    initial en_dim_pin = 1'h0;
    always @(posedge aclk) begin
        if (!run) begin
            en_dim_pin <= 1'h0;
            cnt_q <= 16'h0;
        end else if (cnt_q == 16'h0) begin
            // zero low time: plain enable, no external dimming
            en_dim_pin <= !en_dim_pin || lo_cyc == 16'h0;
            cnt_q <= (en_dim_pin ? lo_cyc : hi_cyc) - 16'h1;
        end else begin
            cnt_q <= cnt_q - 16'h1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/ldpc_dimming_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// port-level checks for the dimming block
// ****************************************************************
module ldpc_dimming_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en_dim_pin,
    input wire logic internal_dim_select,
    input wire logic fault_in,
    input wire logic switching_enable,
    input wire logic output_switch_gate_drive,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // pin path is two sync flops plus an output register
    sequence s_lit;
        (en_dim_pin && internal_dim_select && !fault_in)[*6];
    endsequence
    property p_on;
        s_lit |-> ##2 output_switch_gate_drive && switching_enable;
    endproperty
    property p_off;
        !en_dim_pin |-> ##3 !switching_enable && !output_switch_gate_drive;
    endproperty
    property p_gate_src;
        output_switch_gate_drive |-> $past(en_dim_pin, 3);
    endproperty
    property p_sw_src;
        switching_enable |-> $past(en_dim_pin, 3);
    endproperty
    property p_gate_sw;
        output_switch_gate_drive |-> switching_enable;
    endproperty
    property p_fault;
        fault_in |-> ##3 !output_switch_gate_drive;
    endproperty
    property p_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> s_axi_bvalid;
    endproperty
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_bone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_on: assert property (p_on)
        else $error("outputs not on with enable held");
    a_off: assert property (p_off)
        else $error("outputs not off after enable low");
    a_gate_src: assert property (p_gate_src)
        else $error("gate on without enable");
    a_sw_src: assert property (p_sw_src)
        else $error("switching without enable");
    a_gate_sw: assert property (p_gate_sw)
        else $error("gate on while switching stopped");
    a_fault: assert property (p_fault)
        else $error("gate on during fault");
    a_wr: assert property (p_wr) else $error("no write response");
    a_rd: assert property (p_rd) else $error("no read data");
    a_bone: assert property (p_bone) else $error("response repeated");
endmodule
`default_nettype wire

// ==== tb/test_led_pwm_dimming_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_led_pwm_dimming_control;
    logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, en_dim_pin, fault_in = 1'h0;
    logic internal_dim_select = 1'h1, switching_enable;
    logic output_switch_gate_drive, s_axi_awready, s_axi_wready;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [15:0] hi_cyc = 16'h0, lo_cyc = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    int mismatches = 0;
    int compares = 0;
    // fast clock figures keep one dimming period to a few thousand cycles
    ldpc_dimming #(.CLK_HZ(2000000), .TICK_HZ(2000000)) i_ldpc_dimming (.*);
    ldpc_dim_src i_ldpc_dim_src (.aclk(aclk), .run(run), .hi_cyc(hi_cyc),
        .lo_cyc(lo_cyc), .en_dim_pin(en_dim_pin));
    always #4 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(8'h04, d, r);
        chk(d, 32'h708);
        rd(8'h08, d, r);
        chk(d, 32'h64);
        wr(8'h20, 32'h5, r);
        chk(r, 2'h2);
        rd(8'h20, d, r);
        chk(r, 2'h2);
        wr(8'h00, 32'h1, r);
        rd(8'h0c, d, r);
        chk(d[4:0], 5'h16);
        wr(8'h00, 32'h0, r);
        s_axi_wstrb <= 4'h2;
        wr(8'h04, 32'h300, r);
        wr(8'h00, 32'h1, r);
        s_axi_wstrb <= 4'hf;
        rd(8'h04, d, r);
        chk(d, 32'h308);
        rd(8'h00, d, r);
        chk(d, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_ext();
        int n = 0;
        hi_cyc <= 16'h7;
        lo_cyc <= 16'h5;
        run <= 1'h1;
        repeat (24) @(posedge aclk);
        repeat (120) begin
            @(posedge aclk);
            if (output_switch_gate_drive === 1'h1) n++;
        end
        chk(n, 70);
        run <= 1'h0;
        repeat (5) @(posedge aclk);
        chk({switching_enable, output_switch_gate_drive}, 2'h0);
        $display("test external done");
    endtask
    task automatic t_fault();
        lo_cyc <= 16'h0;
        run <= 1'h1;
        repeat (10) @(posedge aclk);
        chk(output_switch_gate_drive, 1'h1);
        fault_in <= 1'h1;
        repeat (5) @(posedge aclk);
        chk({switching_enable, output_switch_gate_drive}, 2'h2);
        fault_in <= 1'h0;
        repeat (5) @(posedge aclk);
        chk(output_switch_gate_drive, 1'h1);
        $display("test fault done");
    endtask
    task automatic t_gen(input logic [15:0] f, input logic [15:0] du,
                         input int per, input int hi);
        logic [1:0] r;
        int h = 0;
        int l = 0;
        wr(8'h08, {16'h0, f}, r);
        wr(8'h04, {16'h0, du}, r);
        internal_dim_select <= 1'h0;
        while (output_switch_gate_drive !== 1'h0) @(posedge aclk);
        while (output_switch_gate_drive !== 1'h1) @(posedge aclk);
        while (output_switch_gate_drive === 1'h1) begin
            @(posedge aclk);
            h++;
        end
        while (output_switch_gate_drive !== 1'h1) begin
            @(posedge aclk);
            l++;
        end
        chk(h, hi);
        chk(h + l, per);
        $display("test generator done");
    endtask
    task automatic t_full();
        int n = 0;
        internal_dim_select <= 1'h1;
        repeat (8) @(posedge aclk);
        repeat (50) begin
            @(posedge aclk);
            if (output_switch_gate_drive === 1'h1) n++;
        end
        chk(n, 50);
        $display("test full done");
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_ext();
        t_fault();
        t_gen(16'ha, 16'hd5c, 1000, 950);
        t_gen(16'h28, 16'hb4, 4000, 200);
        t_full();
        test_done();
    end
    initial begin
        #600000;
        mismatches++;
        test_done();
    end
endmodule
bind ldpc_dimming ldpc_dimming_chk i_ldpc_dimming_chk (.*);
`default_nettype wire
